//--- pc_stack_consts.svh
// Offsets, field positions, reset values and sizes for the PC and stack block
`ifndef PC_STACK_CONSTS_SVH
`define PC_STACK_CONSTS_SVH

// ==========================================================================
// Register offsets
`define PCS_OFS_PC_LOW 8'h00
`define PCS_OFS_HOLDING 8'h04
`define PCS_OFS_FPTR 8'h08
`define PCS_OFS_BANK 8'h0C
`define PCS_OFS_IND_ADDR 8'h10

// ==========================================================================
// Widths and field positions
`define PCS_PC_W 13
`define PCS_PAGE_LO 11
`define PCS_HOLD_W 5
`define PCS_HOLD_PAGE_HI 4
`define PCS_HOLD_PAGE_LO 3
`define PCS_STACK_DEPTH 8
`define PCS_SP_W 3
`define PCS_IND_W 9
`define PCS_WINDOW_MASK 7'h00
`define PCS_BANK_BIT 0

// ==========================================================================
// Reset values and constants
`define PCS_PC_RST 13'h0000
`define PCS_HOLD_RST 5'h00
`define PCS_FPTR_RST 8'h00
`define PCS_INT_VECTOR 13'h0004
`define PCS_WINDOW_READ 8'h00
`define PCS_RESP_OKAY 2'h0
`define PCS_RESP_SLVERR 2'h2

`endif

//--- pc_stack_pkg.sv
// Types and shared decode for the PC, return stack and indirect addressing
`include "pc_stack_consts.svh"

package pc_stack_pkg;

    // ======================================================================
    // Core SFR select codes
    typedef enum logic [1:0] {
        SEL_PC_LOW = 2'h0,
        SEL_HOLDING = 2'h1,
        SEL_FPTR = 2'h2,
        SEL_BANK = 2'h3
    } sfr_sel_t;

    // ======================================================================
    // Write channel sequencing, one-hot
    typedef enum logic [2:0] {
        WR_COLLECT = 3'h1,
        WR_COMMIT = 3'h2,
        WR_RESPOND = 3'h4
    } wr_state_t;

    typedef struct packed {
        logic [`PCS_PC_W-1:0] pc;
        logic [`PCS_HOLD_W-1:0] holding;
        logic [7:0] fptr;
        logic bank;
        wr_state_t wst;
        logic awready;
        logic wready;
        logic aw_got;
        logic w_got;
        logic [7:0] awaddr;
        logic [7:0] wdata;
        logic wbyte;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } top_state_t;

    typedef struct packed {
        logic [`PCS_STACK_DEPTH-1:0][`PCS_PC_W-1:0] entry;
        logic [`PCS_SP_W-1:0] sp;
    } stack_state_t;

    typedef struct packed {
        logic [`PCS_IND_W-1:0] addr;
        logic rd;
        logic wr;
        logic [7:0] wdata;
        logic hit_window;
        logic rvalid;
        logic [7:0] rdata;
    } ind_state_t;

    // Indirect target lands on the window itself in any bank
    function automatic logic is_window(input logic [`PCS_IND_W-1:0] a);
        is_window = (a[6:0] == `PCS_WINDOW_MASK);
    endfunction : is_window

endpackage : pc_stack_pkg

//--- return_stack.sv
// Eight-entry circular return stack with hidden pointer
`timescale 1ns/1ps
`include "pc_stack_consts.svh"

module return_stack (
    input wire logic clk,
    input wire logic rst,
    input wire logic push,
    input wire logic pop,
    input wire logic [`PCS_PC_W-1:0] push_data,
    output logic [`PCS_PC_W-1:0] pop_data
);
    pc_stack_pkg::stack_state_t st;
    pc_stack_pkg::stack_state_t next_st;
    logic [`PCS_SP_W-1:0] below;

    // ======================================================================
    // Pointer wraps modulo eight; no overflow or underflow flag exists
    always_comb begin
        next_st = st;
        below = st.sp - 3'h1;
        pop_data = st.entry[below];
        if (pop) begin
            next_st.sp = below;
        end else if (push) begin
            next_st.entry[st.sp] = push_data;
            next_st.sp = st.sp + 3'h1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

endmodule : return_stack

//--- indirect_access.sv
// Indirect data addressing through the window register
`timescale 1ns/1ps
`include "pc_stack_consts.svh"

module indirect_access (
    input wire logic clk,
    input wire logic rst,
    input wire logic rd,
    input wire logic wr,
    input wire logic [7:0] wdata,
    input wire logic [7:0] fptr,
    input wire logic bank,
    input wire logic [7:0] mem_rdata,
    output logic [`PCS_IND_W-1:0] mem_addr,
    output logic mem_rd,
    output logic mem_wr,
    output logic [7:0] mem_wdata,
    output logic rvalid,
    output logic [7:0] rdata
);
    pc_stack_pkg::ind_state_t st;
    pc_stack_pkg::ind_state_t next_st;
    logic [`PCS_IND_W-1:0] target;
    logic win;

    // ======================================================================
    // Request issue, then memory data captured one cycle later
    always_comb begin
        next_st = st;
        target = {bank, fptr};
        win = pc_stack_pkg::is_window(target);
        next_st.addr = target;
        next_st.hit_window = win & rd;
        next_st.rd = rd & ~win;
        next_st.wr = wr & ~win;
        next_st.wdata = wdata;
        next_st.rvalid = st.rd | st.hit_window;
        next_st.rdata = st.hit_window ? `PCS_WINDOW_READ : mem_rdata;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign mem_addr = st.addr;
    assign mem_rd = st.rd;
    assign mem_wr = st.wr;
    assign mem_wdata = st.wdata;
    assign rvalid = st.rvalid;
    assign rdata = st.rdata;

endmodule : indirect_access

//--- pc_stack_indirect.sv
// Program counter, return stack, paging and indirect addressing with AXI4-Lite
//
// Function
// - PC is 13 bits; low byte register readable and writable.
// - PC bits 12..8 never accessed directly; register writes load them only from holding register.
// - Any reset clears the whole PC.
// - Low-byte write loads PC 12..8 from holding 4..0 together.
// - Call and jump use 11 instruction bits plus holding bits 4..3.
// - Eight-deep 13-bit return stack with hidden pointer.
// - Push PC on call or interrupt vectoring.
// - Any return pops the stack and restores the full PC.
// - Push and pop leave the holding register unchanged.
// - Stack is circular; ninth push overwrites the first.
// - No overflow or underflow indication at all.
// - 8K-word program space split into 2K pages by page bits.
// - Window register has no storage; accesses go through file pointer.
// - Indirect window read gives 00h; indirect write stores nothing.
// - Indirect address is bank bit above 8-bit file pointer.
`timescale 1ns/1ps
`include "pc_stack_consts.svh"

module pc_stack_indirect (
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic [7:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [7:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire logic CORE_ADVANCE,
    input wire logic CORE_CALL,
    input wire logic CORE_JUMP_BRANCH,
    input wire logic [10:0] CORE_TARGET,
    input wire logic CORE_RETURN,
    input wire logic CORE_RETURN_WITH_LITERAL,
    input wire logic CORE_RETURN_FROM_INTERRUPT,
    input wire logic CORE_INT_VECTOR,
    input wire logic CORE_SFR_WR,
    input wire logic [1:0] CORE_SFR_SEL,
    input wire logic [7:0] CORE_SFR_DATA,
    input wire logic CORE_IND_RD,
    input wire logic CORE_IND_WR,
    input wire logic [7:0] CORE_IND_WDATA,
    output logic CORE_IND_RVALID,
    output logic [7:0] CORE_IND_RDATA,
    output logic [`PCS_PC_W-1:0] FETCH_ADDR,
    output logic [`PCS_IND_W-1:0] DATA_ADDR,
    output logic DATA_RD,
    output logic DATA_WR,
    output logic [7:0] DATA_WDATA,
    input wire logic [7:0] DATA_RDATA
);
    pc_stack_pkg::top_state_t st;
    pc_stack_pkg::top_state_t next_st;
    logic any_return;
    logic do_push;
    logic [`PCS_PC_W-1:0] pop_data;
    logic [`PCS_PC_W-1:0] branch_pc;
    logic [7:0] sel_addr;
    logic [31:0] read_word;
    logic read_hit;
    logic write_hit;

    // ======================================================================
    // Stack and indirect path
    assign any_return = CORE_RETURN | CORE_RETURN_WITH_LITERAL
        | CORE_RETURN_FROM_INTERRUPT;
    assign do_push = CORE_CALL | CORE_INT_VECTOR;

    return_stack u_stack (
        .clk(CLK),
        .rst(SYS_RST),
        .push(do_push & ~any_return),
        .pop(any_return),
        .push_data(st.pc),
        .pop_data(pop_data)
    );

    indirect_access u_ind (
        .clk(CLK),
        .rst(SYS_RST),
        .rd(CORE_IND_RD),
        .wr(CORE_IND_WR),
        .wdata(CORE_IND_WDATA),
        .fptr(st.fptr),
        .bank(st.bank),
        .mem_rdata(DATA_RDATA),
        .mem_addr(DATA_ADDR),
        .mem_rd(DATA_RD),
        .mem_wr(DATA_WR),
        .mem_wdata(DATA_WDATA),
        .rvalid(CORE_IND_RVALID),
        .rdata(CORE_IND_RDATA)
    );

    // ======================================================================
    // Page bits from holding 4..3 above the 11-bit target
    assign branch_pc = {st.holding[`PCS_HOLD_PAGE_HI:`PCS_HOLD_PAGE_LO],
        CORE_TARGET};

    // ======================================================================
    // Register read decode; the high PC bits have no read path
    always_comb begin
        read_word = 32'h0000_0000;
        read_hit = 1'b1;
        case (S_AXI_ARADDR)
            `PCS_OFS_PC_LOW: read_word = {24'h00_0000, st.pc[7:0]};
            `PCS_OFS_HOLDING: read_word = {27'h000_0000, st.holding};
            `PCS_OFS_FPTR: read_word = {24'h00_0000, st.fptr};
            `PCS_OFS_BANK: read_word = {31'h0000_0000, st.bank};
            `PCS_OFS_IND_ADDR: read_word = {23'h00_0000, st.bank, st.fptr};
            default: read_hit = 1'b0;
        endcase
    end

    // Stack pointer and depth are never mapped, and no stack flag exists
    always_comb begin
        sel_addr = st.awaddr;
        case (sel_addr)
            `PCS_OFS_PC_LOW: write_hit = 1'b1;
            `PCS_OFS_HOLDING: write_hit = 1'b1;
            `PCS_OFS_FPTR: write_hit = 1'b1;
            `PCS_OFS_BANK: write_hit = 1'b1;
            default: write_hit = 1'b0;
        endcase
    end

    // ======================================================================
    // Next state
    always_comb begin
        next_st = st;

        // Sequential fetch; 13-bit counter wraps within 8K words
        if (CORE_ADVANCE) begin
            next_st.pc = st.pc + 13'h0001;
        end

        // Write address and data are taken in either order
        case (st.wst)
            pc_stack_pkg::WR_COLLECT: begin
                if (S_AXI_AWVALID && st.awready) begin
                    next_st.aw_got = 1'b1;
                    next_st.awaddr = S_AXI_AWADDR;
                end
                if (S_AXI_WVALID && st.wready) begin
                    next_st.w_got = 1'b1;
                    next_st.wdata = S_AXI_WDATA[7:0];
                    next_st.wbyte = S_AXI_WSTRB[0];
                end
                if (next_st.aw_got && next_st.w_got) begin
                    next_st.wst = pc_stack_pkg::WR_COMMIT;
                end
            end
            pc_stack_pkg::WR_COMMIT: begin
                next_st.bresp = write_hit ? `PCS_RESP_OKAY : `PCS_RESP_SLVERR;
                next_st.bvalid = 1'b1;
                next_st.aw_got = 1'b0;
                next_st.w_got = 1'b0;
                next_st.wst = pc_stack_pkg::WR_RESPOND;
                // Lane 0 carries every register; other lanes are dropped
                if (write_hit && st.wbyte) begin
                    case (st.awaddr)
                        `PCS_OFS_PC_LOW: next_st.pc = {st.holding, st.wdata};
                        `PCS_OFS_HOLDING: next_st.holding = st.wdata[4:0];
                        `PCS_OFS_FPTR: next_st.fptr = st.wdata;
                        `PCS_OFS_BANK: next_st.bank = st.wdata[`PCS_BANK_BIT];
                        default: next_st.bank = st.bank;
                    endcase
                end
            end
            pc_stack_pkg::WR_RESPOND: begin
                if (S_AXI_BREADY) begin
                    next_st.bvalid = 1'b0;
                    next_st.wst = pc_stack_pkg::WR_COLLECT;
                end
            end
            default: begin
                next_st.wst = pc_stack_pkg::WR_COLLECT;
                next_st.bvalid = 1'b0;
            end
        endcase

        // Core writes land after the bus so the running program wins
        if (CORE_SFR_WR) begin
            case (CORE_SFR_SEL)
                pc_stack_pkg::SEL_PC_LOW: next_st.pc = {st.holding, CORE_SFR_DATA};
                pc_stack_pkg::SEL_HOLDING: next_st.holding = CORE_SFR_DATA[4:0];
                pc_stack_pkg::SEL_FPTR: next_st.fptr = CORE_SFR_DATA;
                pc_stack_pkg::SEL_BANK: next_st.bank = CORE_SFR_DATA[`PCS_BANK_BIT];
                default: next_st.fptr = st.fptr;
            endcase
        end

        // Flow changes; the holding register is untouched here
        if (any_return) begin
            next_st.pc = pop_data;
        end else if (CORE_CALL || CORE_JUMP_BRANCH) begin
            next_st.pc = branch_pc;
        end else if (CORE_INT_VECTOR) begin
            next_st.pc = `PCS_INT_VECTOR;
        end

        // Read channel, one outstanding
        if (st.rvalid) begin
            if (S_AXI_RREADY) begin
                next_st.rvalid = 1'b0;
            end
        end else if (S_AXI_ARVALID && st.arready) begin
            next_st.rvalid = 1'b1;
            next_st.rdata = read_word;
            next_st.rresp = read_hit ? `PCS_RESP_OKAY : `PCS_RESP_SLVERR;
        end

        // Ready flags held in flops, derived from the next state
        next_st.awready = (next_st.wst == pc_stack_pkg::WR_COLLECT) & ~next_st.aw_got;
        next_st.wready = (next_st.wst == pc_stack_pkg::WR_COLLECT) & ~next_st.w_got;
        next_st.arready = ~next_st.rvalid;
    end

    // ======================================================================
    // State register
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            st <= '0;
            st.pc <= `PCS_PC_RST;
            st.holding <= `PCS_HOLD_RST;
            st.fptr <= `PCS_FPTR_RST;
            st.wst <= pc_stack_pkg::WR_COLLECT;
        end else begin
            st <= next_st;
        end
    end

    // ======================================================================
    // Outputs, all straight from the state register
    assign S_AXI_AWREADY = st.awready;
    assign S_AXI_WREADY = st.wready;
    assign S_AXI_BVALID = st.bvalid;
    assign S_AXI_BRESP = st.bresp;
    assign S_AXI_ARREADY = st.arready;
    assign S_AXI_RVALID = st.rvalid;
    assign S_AXI_RDATA = st.rdata;
    assign S_AXI_RRESP = st.rresp;
    assign FETCH_ADDR = st.pc;

endmodule : pc_stack_indirect

//--- pc_stack_indirect_properties.sv
// Concurrent checks on the PC, return stack and indirect ports
`timescale 1ns/1ps

module pc_stack_indirect_properties (
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic CORE_CALL,
    input wire logic CORE_JUMP_BRANCH,
    input wire logic [10:0] CORE_TARGET,
    input wire logic CORE_RETURN,
    input wire logic CORE_RETURN_WITH_LITERAL,
    input wire logic CORE_RETURN_FROM_INTERRUPT,
    input wire logic CORE_INT_VECTOR,
    input wire logic CORE_IND_RD,
    input wire logic CORE_IND_WR,
    input wire logic [7:0] CORE_IND_WDATA,
    input wire logic CORE_IND_RVALID,
    input wire logic [7:0] CORE_IND_RDATA,
    input wire logic [12:0] FETCH_ADDR,
    input wire logic [8:0] DATA_ADDR,
    input wire logic DATA_RD,
    input wire logic DATA_WR,
    input wire logic [7:0] DATA_WDATA,
    input wire logic [7:0] DATA_RDATA
);
    wire logic any_ret = CORE_RETURN | CORE_RETURN_WITH_LITERAL | CORE_RETURN_FROM_INTERRUPT;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);

    // ========================================================================
    // Program counter
    sequence s_call; CORE_CALL && !any_ret; endsequence
    sequence s_ret; any_ret; endsequence
    sequence s_ind_hit; CORE_IND_RD ##1 DATA_RD; endsequence
    sequence s_ind_miss; CORE_IND_RD ##1 !DATA_RD; endsequence
    sequence s_ind_wr; CORE_IND_WR ##1 DATA_WR; endsequence
    property p_reset_clear; $fell(SYS_RST) |-> FETCH_ADDR == 13'h0000; endproperty
    a_reset_clear: assert property (p_reset_clear)
        else $error("PC not clear after reset");
    property p_branch; (CORE_CALL || CORE_JUMP_BRANCH) && !any_ret
        |=> FETCH_ADDR[10:0] == $past(CORE_TARGET); endproperty
    a_branch: assert property (p_branch)
        else $error("branch target not loaded");
    property p_vector; CORE_INT_VECTOR && !any_ret && !CORE_CALL && !CORE_JUMP_BRANCH
        |=> FETCH_ADDR == 13'h0004; endproperty
    a_vector: assert property (p_vector)
        else $error("vector not taken");
    property p_call_ret; s_call ##1 s_ret |=> FETCH_ADDR == $past(FETCH_ADDR, 2); endproperty
    a_call_ret: assert property (p_call_ret)
        else $error("return did not restore pushed PC");

    // ========================================================================
    // Indirect access
    property p_ind_answer; CORE_IND_RD |-> ##2 CORE_IND_RVALID; endproperty
    a_ind_answer: assert property (p_ind_answer)
        else $error("indirect read not answered");
    property p_ind_hit; s_ind_hit |=> CORE_IND_RDATA == $past(DATA_RDATA); endproperty
    a_ind_hit: assert property (p_ind_hit)
        else $error("indirect data not passed");
    property p_ind_miss; s_ind_miss |=> CORE_IND_RDATA == 8'h00; endproperty
    a_ind_miss: assert property (p_ind_miss)
        else $error("window read not zero");
    property p_ind_wr; s_ind_wr |-> DATA_WDATA == $past(CORE_IND_WDATA); endproperty
    a_ind_wr: assert property (p_ind_wr)
        else $error("indirect write data wrong");
    property p_no_window; DATA_RD || DATA_WR |-> DATA_ADDR[6:0] != 7'h00; endproperty
    a_no_window: assert property (p_no_window)
        else $error("window itself accessed");
endmodule : pc_stack_indirect_properties

//--- data_mem_model.sv
// Data memory standing behind the indirect address port
`timescale 1ns/1ps

module data_mem_model (
    input wire logic clk,
    input wire logic [8:0] addr,
    input wire logic rd,
    input wire logic wr,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata
);
    logic [7:0] mem [512];
    logic [7:0] last;
    initial begin
        last = 8'h00;
        for (int i = 0; i < 512; i++) mem[i] = 8'(i);
    end
    // Idle bus shows the inverse of its last value, never a stale copy
    assign rdata = rd ? mem[addr] : ~last;
    always @(posedge clk) begin
        if (wr) mem[addr] <= wdata;
        if (rd) last <= mem[addr];
    end
endmodule : data_mem_model

//--- test_pc_stack_indirect.sv
// Self-checking bench for the PC, return stack and indirect addressing block
`timescale 1ns/1ps
`include "pc_stack_consts.svh"

module test_pc_stack_indirect;
    logic CLK, SYS_RST, core_on, p1;
    logic [7:0] S_AXI_AWADDR, S_AXI_ARADDR;
    logic [31:0] S_AXI_WDATA, S_AXI_RDATA;
    logic [3:0] S_AXI_WSTRB;
    logic [1:0] S_AXI_BRESP, S_AXI_RRESP, CORE_SFR_SEL;
    logic S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY, S_AXI_BVALID, S_AXI_BREADY;
    logic S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RREADY, DATA_RD, DATA_WR;
    logic CORE_ADVANCE, CORE_CALL, CORE_JUMP_BRANCH, CORE_RETURN, CORE_RETURN_WITH_LITERAL;
    logic CORE_RETURN_FROM_INTERRUPT, CORE_INT_VECTOR, CORE_SFR_WR, CORE_IND_RD, CORE_IND_WR;
    logic CORE_IND_RVALID, bank_m;
    logic [10:0] CORE_TARGET;
    logic [7:0] CORE_SFR_DATA, CORE_IND_WDATA, CORE_IND_RDATA, DATA_WDATA, DATA_RDATA, fptr_m;
    logic [12:0] FETCH_ADDR, pc_m;
    logic [12:0] stk_m [8];
    logic [7:0] mem_m [512];
    logic [8:0] DATA_ADDR;
    logic [4:0] hold_m;
    logic [2:0] sp_m;
    logic [33:0] q_pc[$], q_b[$], q_r[$], q_ind[$], q_addr[$];
    int n_errors = 0, compares = 0;

    pc_stack_indirect dut_u (.*);
    data_mem_model mem_u (.clk(CLK), .addr(DATA_ADDR), .rd(DATA_RD), .wr(DATA_WR),
        .wdata(DATA_WDATA), .rdata(DATA_RDATA));

    initial begin
        CLK = 1'b0;
        forever #50 CLK = ~CLK;
    end

    // ========================================================================
    // Comparison and closing
    task automatic check(input logic [33:0] seen, input logic [33:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check
    task automatic take(input logic [33:0] seen, ref logic [33:0] q[$]);
        if (q.size() == 0) check(seen, ~seen);
        else check(seen, q.pop_front());
    endtask : take
    task automatic tally_and_finish();
        n_errors += q_pc.size() + q_b.size() + q_r.size() + q_ind.size() + q_addr.size();
        $display("compares %0d, mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : tally_and_finish
    task automatic bail(input int i, input int lim);
        if (i >= lim) begin
            n_errors++;
            tally_and_finish();
        end
    endtask : bail

    // PC and data address are judged two edges after the request, indirect read data three; bus responses at their handshake
    always @(posedge CLK) begin
        p1 <= core_on;
        if (p1) take({21'h0, FETCH_ADDR}, q_pc);
        if (S_AXI_BVALID && S_AXI_BREADY) take({32'h0, S_AXI_BRESP}, q_b);
        if (S_AXI_RVALID && S_AXI_RREADY) take({S_AXI_RRESP, S_AXI_RDATA}, q_r);
        if (CORE_IND_RVALID) take({26'h0, CORE_IND_RDATA}, q_ind);
        if (DATA_RD || DATA_WR) take({25'h0, DATA_ADDR}, q_addr);
    end

    // ========================================================================
    // Register bus
    function automatic logic [33:0] rd_exp(input logic [7:0] a);
        case (a)
            `PCS_OFS_PC_LOW: rd_exp = {26'h0, pc_m[7:0]};
            `PCS_OFS_HOLDING: rd_exp = {29'h0, hold_m};
            `PCS_OFS_FPTR: rd_exp = {26'h0, fptr_m};
            `PCS_OFS_BANK: rd_exp = {33'h0, bank_m};
            `PCS_OFS_IND_ADDR: rd_exp = {25'h0, bank_m, fptr_m};
            default: rd_exp = {2'h2, 32'h0};
        endcase
    endfunction : rd_exp
    task automatic axi_rd(input logic [7:0] a);
        int i;
        i = 0;
        q_r.push_back(rd_exp(a));
        S_AXI_ARADDR <= a;
        S_AXI_ARVALID <= 1'b1;
        S_AXI_RREADY <= 1'b1;
        do begin @(posedge CLK); i++; end while (!S_AXI_ARREADY && i < 20);
        S_AXI_ARVALID <= 1'b0;
        do begin @(posedge CLK); i++; end while (!S_AXI_RVALID && i < 40);
        S_AXI_RREADY <= 1'b0;
        bail(i, 40);
        @(posedge CLK);
    endtask : axi_rd
    task automatic axi_wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] sb);
        int i;
        logic ok;
        logic aw_ok, w_ok;
        i = 0;
        ok = a <= `PCS_OFS_BANK;
        {aw_ok, w_ok} = 2'b00;
        q_b.push_back(ok ? 34'h0 : 34'h2);
        S_AXI_AWADDR <= a;
        S_AXI_WDATA <= {24'($urandom), d};
        S_AXI_WSTRB <= sb;
        S_AXI_AWVALID <= 1'b1;
        S_AXI_WVALID <= 1'b1;
        S_AXI_BREADY <= 1'b1;
        do begin
            @(posedge CLK);
            i++;
            aw_ok |= S_AXI_AWREADY;
            w_ok |= S_AXI_WREADY;
            if (aw_ok) S_AXI_AWVALID <= 1'b0;
            if (w_ok) S_AXI_WVALID <= 1'b0;
        end while (!(aw_ok && w_ok) && i < 20);
        do begin @(posedge CLK); i++; end while (!S_AXI_BVALID && i < 40);
        S_AXI_BREADY <= 1'b0;
        bail(i, 40);
        if (ok && sb[0] && a == `PCS_OFS_PC_LOW) pc_m = {hold_m, d};
        if (ok && sb[0] && a == `PCS_OFS_HOLDING) hold_m = d[4:0];
        @(posedge CLK);
    endtask : axi_wr

    // ========================================================================
    // Core side
    task automatic core(input int op, input logic [10:0] t, input logic [7:0] d);
        CORE_ADVANCE <= op == 1;
        CORE_CALL <= op == 2;
        CORE_JUMP_BRANCH <= op == 3;
        CORE_RETURN <= op == 4;
        CORE_RETURN_WITH_LITERAL <= op == 5;
        CORE_RETURN_FROM_INTERRUPT <= op == 6;
        CORE_INT_VECTOR <= op == 7;
        CORE_SFR_WR <= op >= 8;
        CORE_SFR_SEL <= 2'(op - 8);
        CORE_SFR_DATA <= d;
        CORE_TARGET <= t;
        core_on <= 1'b1;
        case (op)
            1: pc_m = pc_m + 13'h0001;
            2, 7: begin
                stk_m[sp_m] = pc_m;
                sp_m = sp_m + 3'h1;
                pc_m = (op == 7) ? `PCS_INT_VECTOR : {hold_m[4:3], t};
            end
            3: pc_m = {hold_m[4:3], t};
            4, 5, 6: begin
                sp_m = sp_m - 3'h1;
                pc_m = stk_m[sp_m];
            end
            8: pc_m = {hold_m, d};
            9: hold_m = d[4:0];
            10: fptr_m = d;
            11: bank_m = d[0];
            default: ;
        endcase
        q_pc.push_back({21'h0, pc_m});
        @(posedge CLK);
    endtask : core
    task automatic core_end();
        core_on <= 1'b0;
        {CORE_ADVANCE, CORE_CALL, CORE_JUMP_BRANCH, CORE_RETURN} <= 4'h0;
        {CORE_RETURN_WITH_LITERAL, CORE_RETURN_FROM_INTERRUPT, CORE_INT_VECTOR} <= 3'h0;
        CORE_SFR_WR <= 1'b0;
        repeat (2) @(posedge CLK);
    endtask : core_end
    task automatic ind(input logic wr, input logic [7:0] d);
        logic [8:0] a;
        a = {bank_m, fptr_m};
        if (a[6:0] != 7'h00) q_addr.push_back({25'h0, a});
        if (!wr) q_ind.push_back(a[6:0] == 7'h00 ? 34'h0 : {26'h0, mem_m[a]});
        else if (a[6:0] != 7'h00) mem_m[a] = d;
        CORE_IND_RD <= !wr;
        CORE_IND_WR <= wr;
        CORE_IND_WDATA <= d;
        @(posedge CLK);
        CORE_IND_RD <= 1'b0;
        CORE_IND_WR <= 1'b0;
        repeat (3) @(posedge CLK);
    endtask : ind

    // ========================================================================
    // Main sequence
    initial begin
        void'($urandom(67953));
        {SYS_RST, core_on} = 2'b10;
        {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = 5'h00;
        {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA, S_AXI_WSTRB} = {48'h0, 4'hF};
        {CORE_ADVANCE, CORE_CALL, CORE_JUMP_BRANCH, CORE_RETURN, CORE_RETURN_WITH_LITERAL} = 5'h00;
        {CORE_RETURN_FROM_INTERRUPT, CORE_INT_VECTOR, CORE_SFR_WR, CORE_IND_RD, CORE_IND_WR} = 5'h00;
        {CORE_TARGET, CORE_SFR_SEL, CORE_SFR_DATA, CORE_IND_WDATA} = 29'h0;
        {pc_m, hold_m, fptr_m, bank_m, sp_m} = 30'h0;
        repeat (10) @(posedge CLK);
        SYS_RST <= 1'b0;
        for (int k = 0; k < 6; k++) axi_rd(8'(k * 4));
        axi_wr(8'h14, 8'h5A, 4'hF);
        $display("test reset_and_map done");
        core(9, 11'h000, 8'($urandom));
        for (int k = 0; k < 3; k++) core(1, 11'h000, 8'h00);
        core(8, 11'h000, 8'($urandom));
        core(3, 11'($urandom), 8'h00);
        for (int k = 0; k < 9; k++) begin
            core(9, 11'h000, 8'($urandom));
            core(2, 11'($urandom), 8'h00);
        end
        for (int k = 0; k < 10; k++) core(4 + k % 3, 11'h000, 8'h00);
        core(7, 11'h000, 8'h00);
        core(6, 11'h000, 8'h00);
        core_end();
        axi_rd(`PCS_OFS_HOLDING);
        axi_rd(`PCS_OFS_PC_LOW);
        axi_wr(`PCS_OFS_PC_LOW, 8'($urandom), 4'hF);
        axi_wr(`PCS_OFS_PC_LOW, 8'($urandom), 4'hE);
        core(1, 11'h000, 8'h00);
        core_end();
        $display("test paging_and_stack done");
        core(10, 11'h000, 8'($urandom) | 8'h01);
        core(11, 11'h000, 8'($urandom));
        core_end();
        ind(1'b1, 8'($urandom));
        ind(1'b0, 8'h00);
        axi_rd(`PCS_OFS_IND_ADDR);
        core(10, 11'h000, 8'h80);
        core_end();
        ind(1'b1, 8'h77);
        ind(1'b0, 8'h00);
        $display("test indirect done");
        tally_and_finish();
    end
endmodule : test_pc_stack_indirect

bind pc_stack_indirect pc_stack_indirect_properties chk_u (.*);
